// ---- core/pwrb_pkg.sv ----
// package: register map, field layout and state carriers for the power budget registers
package pwrb_pkg;

  // register byte addresses
  localparam logic [11:0] PWRB_CAP_HEADER_ADDR  = 12'h280;
  localparam logic [11:0] PWRB_DATA_SELECT_ADDR = 12'h284;
  localparam logic [11:0] PWRB_DATA_WINDOW_ADDR = 12'h288;
  localparam logic [11:0] PWRB_ALLOC_FLAG_ADDR  = 12'h28c;
  localparam logic [11:0] PWRB_VALUE_BASE_ADDR  = 12'h300;
  localparam logic [11:0] PWRB_UNLOCK_CTRL_ADDR = 12'h3f0;

  // data value registers
  localparam int          PWRB_NUM_VALUES = 8;
  localparam logic [7:0]  PWRB_SEL_MAX    = 8'h07;
  localparam logic [2:0]  PWRB_VAL_IDX_W0 = 3'h0;

  // field positions
  localparam int PWRB_CAPABILITY_IDENTIFIER_LSB   = 0;
  localparam int PWRB_CAPABILITY_IDENTIFIER_MSB   = 15;
  localparam int PWRB_CAPABILITY_VERSION_LSB  = 16;
  localparam int PWRB_CAPABILITY_VERSION_MSB  = 19;
  localparam int PWRB_NEXT_STRUCTURE_POINTER_LSB  = 20;
  localparam int PWRB_NEXT_STRUCTURE_POINTER_MSB  = 31;
  localparam int PWRB_SEL_MSB     = 7;
  localparam int PWRB_SA_BIT      = 0;
  localparam int PWRB_UNLOCK_BIT  = 0;

  // documented field values when the structure is in use
  localparam logic [15:0] PWRB_CAPABILITY_IDENTIFIER_POWER_BUDGET = 16'h0004;
  localparam logic [3:0]  PWRB_CAPABILITY_VERSION_ONE         = 4'h1;

  // reset values
  localparam logic [31:0] PWRB_HEADER_RESET = 32'h0000_0000;
  localparam logic [7:0]  PWRB_SEL_RESET    = 8'h00;
  localparam logic [31:0] PWRB_VALUE_RESET  = 32'h0000_0000;
  localparam logic [31:0] PWRB_ZERO_WORD    = 32'h0000_0000;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } pwrb_apb_req_t;

  // apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pwrb_apb_rsp_t;

  // all state of the register block
  typedef struct packed {
    logic [31:0]                      header;
    logic [7:0]                       select;
    logic                             sys_alloc;
    logic                             unlock;
    logic [PWRB_NUM_VALUES-1:0][31:0] values;
    logic [31:0]                      rdata;
    logic                             slverr;
    logic                             ack;
  } pwrb_state_t;

endpackage

// ---- core/pwrb_regs.sv ----
// power budgeting capability register block behind an apb slave
//
// Behaviour
// - identifier field reports 0x4 when used
// - version field reports 0x1 when used
// - selector bits 7:0 pick data value
// - selector above 7 reads window zero
// - read-only window returns selected value
// - bit 0 flags power already allocated
// - value registers writable only when unlocked
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pwrb_regs
  import pwrb_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic               pslverr,
  output logic [31:0]        prdata,
  // status towards the switch
  output logic               budget_value_unlock,
  output logic               system_allocated_flag,
  output logic [15:0]        capability_identifier,
  output logic [3:0]         capability_version
);

  pwrb_apb_req_t req;
  pwrb_apb_rsp_t rsp;
  pwrb_state_t   s_q;
  pwrb_state_t   s_d;

  logic [31:0] window_word;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        is_value;
  logic [2:0]  value_idx;
  logic        mapped;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata, pstrb: pstrb};

  // window mux, zero for out of range selector
  always_comb begin
    if (s_q.select > PWRB_SEL_MAX) begin
      window_word = PWRB_ZERO_WORD;
    end else begin
      window_word = s_q.values[s_q.select[2:0]];
    end
  end

  // only the first access edge acts, the answer edge does not repeat it
  assign access    = req.psel & req.penable & ~s_q.ack;
  assign wr_en     = access & req.pwrite;
  assign rd_en     = access & ~req.pwrite;
  assign is_value  = (req.paddr >= PWRB_VALUE_BASE_ADDR) &&
                     (req.paddr < PWRB_VALUE_BASE_ADDR + 12'(PWRB_NUM_VALUES * 4));
  assign value_idx = 3'(req.paddr[4:2] - PWRB_VAL_IDX_W0);

  always_comb begin
    mapped = 1'b1;
    case (req.paddr)
      PWRB_CAP_HEADER_ADDR, PWRB_DATA_SELECT_ADDR, PWRB_DATA_WINDOW_ADDR,
      PWRB_ALLOC_FLAG_ADDR, PWRB_UNLOCK_CTRL_ADDR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = is_value && (req.paddr[1:0] == 2'b00);
      end
    endcase
  end

  // byte-lane merge
  function automatic logic [31:0] pwrb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    s_d        = s_q;
    s_d.slverr = 1'b0;
    s_d.ack    = access;
    if (access) begin
      s_d.slverr = ~mapped;
      s_d.rdata  = PWRB_ZERO_WORD;
    end
    if (wr_en && mapped) begin
      case (req.paddr)
        PWRB_CAP_HEADER_ADDR: begin
          if (s_q.unlock) begin
            s_d.header = pwrb_merge(s_q.header, req.pwdata, req.pstrb);
          end
        end
        PWRB_DATA_SELECT_ADDR: begin
          if (req.pstrb[0]) begin
            s_d.select = req.pwdata[PWRB_SEL_MSB:0];
          end
        end
        PWRB_ALLOC_FLAG_ADDR: begin
          if (s_q.unlock && req.pstrb[0]) begin
            s_d.sys_alloc = req.pwdata[PWRB_SA_BIT];
          end
        end
        PWRB_UNLOCK_CTRL_ADDR: begin
          if (req.pstrb[0]) begin
            s_d.unlock = req.pwdata[PWRB_UNLOCK_BIT];
          end
        end
        default: begin
          if (is_value && s_q.unlock) begin
            s_d.values[value_idx] = pwrb_merge(s_q.values[value_idx], req.pwdata,
                                               req.pstrb);
          end
        end
      endcase
    end
    if (rd_en && mapped) begin
      case (req.paddr)
        PWRB_CAP_HEADER_ADDR:  s_d.rdata = s_q.header;
        PWRB_DATA_SELECT_ADDR: s_d.rdata = {24'h000000, s_q.select};
        PWRB_DATA_WINDOW_ADDR: s_d.rdata = window_word;
        PWRB_ALLOC_FLAG_ADDR:  s_d.rdata = {31'h00000000, s_q.sys_alloc};
        PWRB_UNLOCK_CTRL_ADDR: s_d.rdata = {31'h00000000, s_q.unlock};
        default:               s_d.rdata = s_q.values[value_idx];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.header    <= PWRB_HEADER_RESET;
      s_q.select    <= PWRB_SEL_RESET;
      s_q.sys_alloc <= 1'b0;
      s_q.unlock    <= 1'b0;
      s_q.values    <= {PWRB_NUM_VALUES{PWRB_VALUE_RESET}};
      s_q.rdata     <= PWRB_ZERO_WORD;
      s_q.slverr    <= 1'b0;
      s_q.ack       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // answer one cycle after the first access edge, data registered
  logic ack_q;
  assign ack_q = s_q.ack;

  assign rsp.pready  = ack_q;
  assign rsp.pslverr = s_q.slverr & ack_q;
  assign rsp.prdata  = s_q.rdata;
  assign pready      = rsp.pready;
  assign pslverr     = rsp.pslverr;
  assign prdata      = rsp.prdata;

  assign budget_value_unlock   = s_q.unlock;
  assign system_allocated_flag = s_q.sys_alloc;
  assign capability_identifier = s_q.header[PWRB_CAPABILITY_IDENTIFIER_MSB:PWRB_CAPABILITY_IDENTIFIER_LSB];
  assign capability_version    = s_q.header[PWRB_CAPABILITY_VERSION_MSB:PWRB_CAPABILITY_VERSION_LSB];

  // assertions
  chk_window_zero_high: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !ack_q && paddr == PWRB_DATA_WINDOW_ADDR && s_q.select > PWRB_SEL_MAX)
      |=> (prdata == PWRB_ZERO_WORD))
    else $error("window not zero for large selector");

  chk_window_value_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !ack_q && paddr == PWRB_DATA_WINDOW_ADDR && s_q.select <= PWRB_SEL_MAX)
      |=> (prdata == $past(s_q.values[s_q.select[2:0]])))
    else $error("window does not show selected value");

  chk_select_write_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !ack_q && paddr == PWRB_DATA_SELECT_ADDR && pstrb[0])
      |=> (s_q.select == $past(pwdata[7:0])))
    else $error("selector not written");

  chk_value_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && is_value && !s_q.unlock) |=> $stable(s_q.values))
    else $error("value register written while locked");

  chk_header_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_q.unlock) |=> $stable(s_q.header) && $stable(s_q.sys_alloc))
    else $error("lockable field changed while locked");

  chk_header_unlock_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && s_q.unlock && paddr == PWRB_CAP_HEADER_ADDR && pstrb == 4'hf)
      |=> (capability_identifier == $past(pwdata[15:0])))
    else $error("identifier not written while unlocked");

  chk_version_unlock_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && s_q.unlock && paddr == PWRB_CAP_HEADER_ADDR && pstrb == 4'hf)
      |=> (capability_version == $past(pwdata[19:16])))
    else $error("version not written while unlocked");

  chk_alloc_flag_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && s_q.unlock && paddr == PWRB_ALLOC_FLAG_ADDR && pstrb[0])
      |=> (system_allocated_flag == $past(pwdata[0])))
    else $error("allocation flag not written");

  chk_apb_ready_two: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |-> ##1 pready)
    else $error("access not answered in one wait cycle");

  // bus answer
  chk_ready_after_access: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> pready)
    else $error("first access edge not answered");

  chk_ready_in_access: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (psel && penable))
    else $error("ready raised outside an access phase");

  chk_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !mapped) |=> pslverr)
    else $error("unmapped access not flagged");

  chk_error_mapped_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (access && mapped) |=> !pslverr)
    else $error("mapped access flagged as error");

  chk_error_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !mapped) |=> (prdata == PWRB_ZERO_WORD))
    else $error("unmapped read returned data");

  chk_rdata_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!access) |=> $stable(prdata))
    else $error("read data moved outside an access");

  // read path
  chk_header_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == PWRB_CAP_HEADER_ADDR) |=> (prdata == $past(s_q.header)))
    else $error("header read does not match register");

  chk_select_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == PWRB_DATA_SELECT_ADDR)
      |=> ((prdata >> (PWRB_SEL_MSB + 1)) == PWRB_ZERO_WORD))
    else $error("selector reserved bits not zero");

  chk_alloc_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == PWRB_ALLOC_FLAG_ADDR)
      |=> ((prdata >> (PWRB_SA_BIT + 1)) == PWRB_ZERO_WORD))
    else $error("allocation reserved bits not zero");

  chk_alloc_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == PWRB_ALLOC_FLAG_ADDR)
      |=> (prdata[PWRB_SA_BIT] == $past(system_allocated_flag)))
    else $error("allocation flag read does not match");

  chk_value_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && mapped && is_value) |=> (prdata == s_q.values[$past(value_idx)]))
    else $error("data value read does not match");

  // write path
  chk_select_lane_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PWRB_DATA_SELECT_ADDR && !pstrb[0]) |=> $stable(s_q.select))
    else $error("selector changed without its byte lane");

  chk_window_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PWRB_DATA_WINDOW_ADDR)
      |=> ($stable(s_q.values) && $stable(s_q.select) && $stable(s_q.header)))
    else $error("write to read-only window changed state");

  chk_next_structure_pointer_unlock_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && s_q.unlock && paddr == PWRB_CAP_HEADER_ADDR && pstrb == 4'hf)
      |=> (s_q.header[PWRB_NEXT_STRUCTURE_POINTER_MSB:PWRB_NEXT_STRUCTURE_POINTER_LSB] ==
           $past(pwdata[PWRB_NEXT_STRUCTURE_POINTER_MSB:PWRB_NEXT_STRUCTURE_POINTER_LSB])))
    else $error("next pointer not written while unlocked");

  chk_unlock_write_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == PWRB_UNLOCK_CTRL_ADDR && pstrb[0])
      |=> (budget_value_unlock == $past(pwdata[PWRB_UNLOCK_BIT])))
    else $error("unlock bit not written");

  chk_value_unlock_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && mapped && is_value && s_q.unlock && pstrb == 4'hf)
      |=> (s_q.values[$past(value_idx)] == $past(pwdata)))
    else $error("data value not written while unlocked");

  // one hold check per data value entry
  for (genvar g = 0; g < PWRB_NUM_VALUES; g++) begin : g_value_chk
    chk_value_entry_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && is_value && s_q.unlock && value_idx == 3'(g)) |=> $stable(s_q.values[g]))
      else $error("data value entry changed without its write");
  end

endmodule

`default_nettype wire

// ---- dv/pwrb_tb.sv ----
// self-checking apb bench for the power budget register block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pwrb_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        budget_value_unlock;
  logic        system_allocated_flag;
  logic [15:0] capability_identifier;
  logic [3:0]  capability_version;
  logic [31:0] rd_q;
  logic        err_q;
  int          fail_count;
  int          cmp_count;

  pwrb_regs i_pwrb_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .budget_value_unlock(budget_value_unlock),
    .system_allocated_flag(system_allocated_flag),
    .capability_identifier(capability_identifier), .capability_version(capability_version)
  );

  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; answer taken at the edge where pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      input logic [3:0] strb);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data, 4'hf);
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    xfer(1'b0, addr, 32'h0, 4'hf);
    chk(rd_q, exp);
    chk({31'h0, err_q}, {31'h0, exp_err});
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    summarize;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(PWRB_CAP_HEADER_ADDR, 32'h0, 1'b0);
    rd(PWRB_DATA_SELECT_ADDR, 32'h0, 1'b0);
    rd(PWRB_DATA_WINDOW_ADDR, 32'h0, 1'b0);
    rd(PWRB_ALLOC_FLAG_ADDR, 32'h0, 1'b0);
    done("reset");
    // writes while locked are dropped
    wr(PWRB_CAP_HEADER_ADDR, 32'h0121_0004);
    wr(PWRB_ALLOC_FLAG_ADDR, 32'h0000_0001);
    wr(PWRB_VALUE_BASE_ADDR, 32'h1234_5678);
    rd(PWRB_CAP_HEADER_ADDR, 32'h0, 1'b0);
    rd(PWRB_ALLOC_FLAG_ADDR, 32'h0, 1'b0);
    rd(PWRB_VALUE_BASE_ADDR, 32'h0, 1'b0);
    done("locked");
    // unlock and load the structure fields after reset
    wr(PWRB_UNLOCK_CTRL_ADDR, 32'h1);
    chk({31'h0, budget_value_unlock}, 32'h1);
    wr(PWRB_CAP_HEADER_ADDR, 32'h0121_0004);
    rd(PWRB_CAP_HEADER_ADDR, 32'h0121_0004, 1'b0);
    chk({16'h0, capability_identifier}, 32'h4);
    chk({28'h0, capability_version}, 32'h1);
    wr(PWRB_ALLOC_FLAG_ADDR, 32'hffff_ffff);
    rd(PWRB_ALLOC_FLAG_ADDR, 32'h1, 1'b0);
    chk({31'h0, system_allocated_flag}, 32'h1);
    done("unlocked");
    // every selector through the window, plus a single-lane write
    for (int i = 0; i < 8; i++) wr(PWRB_VALUE_BASE_ADDR + 12'(4 * i), 32'hc0de_0000 + i);
    xfer(1'b1, PWRB_VALUE_BASE_ADDR, 32'hffff_ff55, 4'h1);
    for (int i = 0; i < 8; i++) begin
      wr(PWRB_DATA_SELECT_ADDR, 32'(i));
      rd(PWRB_DATA_WINDOW_ADDR, (i == 0) ? 32'hc0de_0055 : 32'hc0de_0000 + i, 1'b0);
    end
    wr(PWRB_DATA_SELECT_ADDR, 32'h8);
    rd(PWRB_DATA_WINDOW_ADDR, 32'h0, 1'b0);
    wr(PWRB_DATA_SELECT_ADDR, 32'hffff_ffff);
    rd(PWRB_DATA_SELECT_ADDR, 32'hff, 1'b0);
    rd(PWRB_DATA_WINDOW_ADDR, 32'h0, 1'b0);
    wr(PWRB_DATA_SELECT_ADDR, 32'h1);
    xfer(1'b1, PWRB_DATA_SELECT_ADDR, 32'h0000_0003, 4'he);
    wr(PWRB_DATA_WINDOW_ADDR, 32'h1234_5678);
    chk({31'h0, err_q}, 32'h0);
    rd(PWRB_DATA_WINDOW_ADDR, 32'hc0de_0001, 1'b0);
    done("window");
    // bad addresses and relock
    rd(12'h400, 32'h0, 1'b1);
    rd(12'h282, 32'h0, 1'b1);
    wr(PWRB_UNLOCK_CTRL_ADDR, 32'h0);
    chk({31'h0, budget_value_unlock}, 32'h0);
    wr(PWRB_VALUE_BASE_ADDR + 12'h4, 32'h0);
    rd(PWRB_DATA_WINDOW_ADDR, 32'hc0de_0001, 1'b0);
    wr(PWRB_CAP_HEADER_ADDR, 32'h0);
    rd(PWRB_CAP_HEADER_ADDR, 32'h0121_0004, 1'b0);
    done("errors");
    // reset again in mid-run, loaded fields must clear
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(PWRB_CAP_HEADER_ADDR, 32'h0, 1'b0);
    rd(PWRB_DATA_SELECT_ADDR, 32'h0, 1'b0);
    chk({16'h0, capability_identifier}, 32'h0);
    done("second reset");
    summarize;
  end

endmodule

`default_nettype wire
